// file: src/led_driver_shutdown_control.sv
// led driver shutdown sequencer: software and hardware shutdown control
// assumes the register file sits outside and hands in the soft_shutdown_n bit
// assumes the serial bus logic takes serialResetN as a synchronous reset
// assumes one mclk domain; only the shutdown pin arrives asynchronously
`timescale 1ns/1ps

module led_driver_shutdown_control (
    input  wire logic  mclk,             // 10 MHz clock
    input  wire logic  nrst,             // synchronous reset, active low
    input  wire logic  hwShutdownPinN,   // hw_shutdown_pin_n, asynchronous pin
    input  wire logic  softShutdownN,    // soft_shutdown_n from control register
    input  wire logic  ctrlRegWrite,     // register file wrote the control register
    output logic       sinkEnable,       // output sinks may conduct
    output logic       analogEnable,     // analog blocks powered
    output logic       regAccessEnable,  // serial bus may read and write registers
    output logic       regClearBlock,    // holds register contents, blocks clear
    output logic       serialResetN,     // serial interface reset, active low
    output logic       resumeOutputs,    // one-cycle pulse on return to run
    output logic [1:0] pwrState          // current operating state
);

    // synchronised pin
    logic                      pinLevel;
    logic                      pinRise;

    // stored soft bit and serial reset counter
    logic                      ssdN_q;
    logic [7:0]                serCnt_q;

    // state and the enables it selects
    shutdown_pkg::pwr_state_t  state_q;
    shutdown_pkg::pwr_state_t  state_d;
    shutdown_pkg::pwr_ctrl_t   ctrl_d;

    // output flops, one per output so each port leaves a register
    logic                      sinkEn_q;
    logic                      analogEn_q;
    logic                      keep_q;
    logic                      accessEn_q;
    logic                      resume_q;
    logic                      serRstN_q;

    // pin is asynchronous, synchronise before any decision
    pin_sync #(
        .RESET_VAL (shutdown_pkg::PIN_RESET_VAL)
    ) u_pin_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .pinAsync (hwShutdownPinN),
        .pinLevel (pinLevel),
        .pinRise  (pinRise)
    );

    // capture the software bit; same domain so no synchroniser needed
    // a write with the pin low is kept and acts on release
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ssdN_q <= shutdown_pkg::SSD_RESET_VAL;
        end else if (ctrlRegWrite) begin
            ssdN_q <= softShutdownN;
        end
    end

    // hardware shutdown outranks software: it also drops the analog blocks
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            // running: either shutdown route pulls out of run
            shutdown_pkg::ST_RUN: begin
                if (!pinLevel) begin
                    state_d = shutdown_pkg::ST_HARD_OFF;
                end else if (!ssdN_q) begin
                    state_d = shutdown_pkg::ST_SOFT_OFF;
                end
            end
            // soft off: pin can still force hard off, a set bit resumes
            shutdown_pkg::ST_SOFT_OFF: begin
                if (!pinLevel) begin
                    state_d = shutdown_pkg::ST_HARD_OFF;
                end else if (ssdN_q) begin
                    state_d = shutdown_pkg::ST_RUN;
                end
            end
            // hard off: only the pin releases, then the soft bit decides
            // where to land, so a bit written during shutdown is honoured
            shutdown_pkg::ST_HARD_OFF: begin
                if (pinLevel && ssdN_q) begin
                    state_d = shutdown_pkg::ST_RUN;
                end else if (pinLevel) begin
                    state_d = shutdown_pkg::ST_SOFT_OFF;
                end
            end
            // unused code: park in hard off, the safest dark state
            default: begin
                state_d = shutdown_pkg::ST_HARD_OFF;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q <= shutdown_pkg::ST_SOFT_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // enables per state; registers are always held and always reachable
    always_comb begin
        ctrl_d.regKeep = 1'b1;
        unique case (state_d)
            // running: everything on
            shutdown_pkg::ST_RUN: begin
                ctrl_d.analogEn = 1'b1;
                ctrl_d.sinkEn   = 1'b1;
            end
            // soft off: analog stays up, only the sinks go dark
            shutdown_pkg::ST_SOFT_OFF: begin
                ctrl_d.analogEn = 1'b1;
                ctrl_d.sinkEn   = 1'b0;
            end
            // hard off: analog and sinks both down
            shutdown_pkg::ST_HARD_OFF: begin
                ctrl_d.analogEn = 1'b0;
                ctrl_d.sinkEn   = 1'b0;
            end
        endcase
    end

    // sinks: off through reset so no led flashes before the bit is read
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sinkEn_q <= 1'b0;
        end else begin
            sinkEn_q <= ctrl_d.sinkEn;
        end
    end

    // analog: follows the next state so it drops with the state change
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            analogEn_q <= 1'b0;
        end else begin
            analogEn_q <= ctrl_d.analogEn;
        end
    end

    // hold flag: never cleared by either shutdown
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            keep_q <= 1'b1;
        end else begin
            keep_q <= ctrl_d.regKeep;
        end
    end

    // bus access: open in every state, reset included, so the host
    // can configure during either shutdown
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            accessEn_q <= 1'b1;
        end else begin
            accessEn_q <= 1'b1;
        end
    end

    // resume pulse: outputs restart from retained settings, nothing rewritten
    // fires on entry to run from either shutdown; leaving reset alone gives no pulse
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= (state_d == shutdown_pkg::ST_RUN) && (state_q != shutdown_pkg::ST_RUN);
        end
    end

    // serial reset length: loaded on each pin rise, counts down to zero
    // so the bus logic sees a clean pulse of known width
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serCnt_q <= 8'h00;
        end else if (pinRise) begin
            serCnt_q <= 8'(shutdown_pkg::SER_RESET_CYC);
        end else if (serCnt_q != 8'h00) begin
            serCnt_q <= serCnt_q - 8'h01;
        end
    end

    // serial reset output from its own flop, low while counting;
    // a rise during the pulse reloads and stretches it
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serRstN_q <= 1'b1;
        end else if (pinRise) begin
            serRstN_q <= 1'b0;
        end else if (serCnt_q != 8'h00) begin
            serRstN_q <= (serCnt_q == 8'h01);
        end else begin
            serRstN_q <= 1'b1;
        end
    end

    // ports straight from the flops above
    assign sinkEnable      = sinkEn_q;
    assign analogEnable    = analogEn_q;
    assign regClearBlock   = keep_q;
    assign regAccessEnable = accessEn_q; // access never gated by shutdown
    assign serialResetN    = serRstN_q;
    assign resumeOutputs   = resume_q;
    assign pwrState        = state_q;

endmodule // led_driver_shutdown_control

// file: src/shutdown_pkg.sv
// shutdown control package: types and constants shared by the sequencer files
// assumes a single 10 MHz clock domain, no register bus reaches this block
package shutdown_pkg;

    localparam int          CLK_PERIOD_NS   = 100;     // mclk period
    localparam int          SER_RESET_NS    = 200;     // least width of the serial-logic reset pulse
    localparam int          SER_RESET_CYC   = (SER_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SYNC_STAGES     = 2;       // flip-flops ahead of any logic on the pin
    localparam logic        PIN_RESET_VAL   = 1'b1;    // pin assumed released until sampled
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;   // control register holding soft_shutdown_n
    localparam int          SSD_BIT         = 0;       // soft_shutdown_n position in control register
    localparam logic        SSD_RESET_VAL   = 1'b0;    // control resets to 00h: software shutdown

    // operating states of the sequencer
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SOFT_OFF,
        ST_HARD_OFF
    } pwr_state_t;

    // enables handed to the output and analog sections
    typedef struct packed {
        logic analogEn;   // bias and oscillator analog blocks
        logic sinkEn;     // output current sinks
        logic regKeep;    // register file must hold (write guard stays off)
    } pwr_ctrl_t;

endpackage

// file: src/pin_sync.sv
// two-stage synchroniser with rising-edge detect on the synchronised level
// assumes the input pin is asynchronous to mclk
`timescale 1ns/1ps

module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic mclk,      // system clock
    input  wire logic nrst,      // synchronous reset, active low
    input  wire logic pinAsync,  // raw pin level
    output logic      pinLevel,  // synchronised level
    output logic      pinRise    // one-cycle pulse on a rising edge
);

    logic stage1_q;
    logic stage2_q;
    logic prev_q;

    // first stage feeds only the second stage, so metastability stays contained
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            prev_q   <= RESET_VAL;
        end else begin
            stage1_q <= pinAsync;
            stage2_q <= stage1_q;
            prev_q   <= stage2_q;
        end
    end

    assign pinLevel = stage2_q;
    assign pinRise  = stage2_q & ~prev_q;

endmodule // pin_sync

// file: verification/led_driver_shutdown_control_props.sv
// checker for the shutdown sequencer ports
// assumes one mclk domain, nrst synchronous active low
`timescale 1ns/1ps
module shutdown_props (
    input wire logic       mclk,            // clock
    input wire logic       nrst,            // reset, active low
    input wire logic       hwShutdownPinN,  // shutdown pin
    input wire logic       softShutdownN,   // control bit
    input wire logic       ctrlRegWrite,    // control write
    input wire logic       sinkEnable,      // sinks on
    input wire logic       analogEnable,    // analog on
    input wire logic       regAccessEnable, // bus access
    input wire logic       regClearBlock,   // register hold
    input wire logic       serialResetN,    // serial reset
    input wire logic       resumeOutputs,   // resume pulse
    input wire logic [1:0] pwrState         // state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // stored soft bit needs its capture flop plus the state update
    property p_softOff; ctrlRegWrite && !softShutdownN |-> ##2 !sinkEnable; endproperty
    a_softOff: assert property (p_softOff) else $error("sinks on after soft off");
    property p_darkSoft; pwrState == shutdown_pkg::ST_SOFT_OFF |-> !sinkEnable; endproperty
    a_darkSoft: assert property (p_darkSoft) else $error("sinks on in soft off");
    property p_hardOn; !hwShutdownPinN [*5] |-> !analogEnable && !sinkEnable; endproperty
    a_hardOn: assert property (p_hardOn) else $error("analog on with pin low");
    property p_hardOff; hwShutdownPinN [*5] |-> pwrState != shutdown_pkg::ST_HARD_OFF; endproperty
    a_hardOff: assert property (p_hardOff) else $error("hard off with pin high");
    property p_serRst; $rose(hwShutdownPinN) |-> ##[1:6] !serialResetN; endproperty
    a_serRst: assert property (p_serRst) else $error("no serial reset");
    property p_access; regAccessEnable; endproperty
    a_access: assert property (p_access) else $error("access closed");
    property p_keep; regClearBlock; endproperty
    a_keep: assert property (p_keep) else $error("register hold dropped");
    property p_resume; $rose(sinkEnable) |-> resumeOutputs; endproperty
    a_resume: assert property (p_resume) else $error("no resume pulse");
    c_resume: cover property (resumeOutputs);
    c_serRst: cover property (!serialResetN);
    c_hard: cover property (pwrState == shutdown_pkg::ST_HARD_OFF);
endmodule // shutdown_props
bind led_driver_shutdown_control shutdown_props u_shutdown_props (.*);

// file: verification/host_model.sv
// host on the far side: drives the shutdown pin and control writes
// assumes the bench calls its tasks; changes land at the falling edge
`timescale 1ns/1ps
module host_model (
    input wire logic mclk,  // clock
    output logic     pinN,  // shutdown pin, active low
    output logic     softN, // control bit value
    output logic     wr     // control write pulse
);
    initial begin pinN = 1'b1; softN = 1'b0; wr = 1'b0; end
    // bit invalid outside the write, so show its inverse
    task automatic writeCtrl(input logic v);
        @(negedge mclk); softN = v; wr = 1'b1;
        @(negedge mclk); wr = 1'b0; softN = ~v;
    endtask
    task automatic setPin(input logic v);
        @(negedge mclk); pinN = v;
    endtask
endmodule // host_model

// file: verification/tb.sv
// self-checking bench for the shutdown sequencer
// assumes 10 MHz mclk and the host model on the far side
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, nrst = 1'b0, pinN, softN, wr, sink, analog, acc, keep, serN, res;
    logic [1:0] st;
    int errCount = 0, checkCount = 0, cycles = 0, lows, seen;
    always #50 mclk = ~mclk;
    host_model u_host (.mclk(mclk), .pinN(pinN), .softN(softN), .wr(wr));
    led_driver_shutdown_control u_led_driver_shutdown_control (.mclk(mclk), .nrst(nrst),
        .hwShutdownPinN(pinN), .softShutdownN(softN), .ctrlRegWrite(wr), .sinkEnable(sink),
        .analogEnable(analog), .regAccessEnable(acc), .regClearBlock(keep),
        .serialResetN(serN), .resumeOutputs(res), .pwrState(st));
    task automatic giveVerdict();
        if (errCount == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [1:0] e, input logic [1:0] g);
        checkCount++;
        if (g !== e) begin errCount++; $display("MISMATCH %s exp %h got %h", n, e, g); end
    endtask
    // soft bit toggled both ways, each write given three cycles before its checks
    task automatic softScen();
        u_host.writeCtrl(1'b1); repeat (3) @(negedge mclk);
        chk("sink", 2'h1, {1'b0, sink});
        chk("state", shutdown_pkg::ST_RUN, st);
        u_host.writeCtrl(1'b0); repeat (3) @(negedge mclk);
        chk("sink", 2'h0, {1'b0, sink});
        chk("state", shutdown_pkg::ST_SOFT_OFF, st);
        chk("access", 2'h1, {1'b0, acc});
        chk("analog", 2'h1, {1'b0, analog});
    endtask
    // soft off held through a pin shutdown: release lands in soft off
    task automatic hardSoftScen();
        u_host.writeCtrl(1'b0); u_host.setPin(1'b0); repeat (6) @(negedge mclk);
        chk("state", shutdown_pkg::ST_HARD_OFF, st);
        u_host.setPin(1'b1); seen = 0;
        repeat (6) begin @(negedge mclk); seen |= res; end
        chk("state", shutdown_pkg::ST_SOFT_OFF, st);
        chk("sink", 2'h0, {1'b0, sink});
        chk("resume", 2'h0, 2'(seen));
    endtask
    // pin shutdown from run, write inside it, then release
    task automatic hardScen();
        u_host.writeCtrl(1'b1); u_host.setPin(1'b0); repeat (6) @(negedge mclk);
        chk("analog", 2'h0, {1'b0, analog});
        chk("state", shutdown_pkg::ST_HARD_OFF, st);
        chk("access", 2'h1, {1'b0, acc});
        chk("keep", 2'h1, {1'b0, keep});
        u_host.writeCtrl(1'b1);
        u_host.setPin(1'b1); lows = 0; seen = 0;
        repeat (10) begin @(negedge mclk); lows += !serN; seen |= res; end
        chk("serLow", 2'(shutdown_pkg::SER_RESET_CYC), 2'(lows));
        chk("resume", 2'h1, 2'(seen));
        chk("sink", 2'h1, {1'b0, sink});
        chk("state", shutdown_pkg::ST_RUN, st);
    endtask
    // cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin errCount++; giveVerdict(); end
    end
    initial begin
        repeat (3) @(negedge mclk);
        nrst = 1'b1; @(negedge mclk);
        chk("state", shutdown_pkg::ST_SOFT_OFF, st);
        softScen();
        hardScen();
        hardSoftScen();
        giveVerdict();
    end
endmodule // tb
